// ===== verilog/cpmc_defs.vh
// Purpose: constants for the clock and power-mode controller
// Assumes: single 125 MHz system clock standing in for the main oscillator
// Notes: bit positions follow the two system clock control bytes
`ifndef CPMC_DEFS_VH
`define CPMC_DEFS_VH
`define CPMC_CR0_OSEL_LO 0
`define CPMC_CR0_OSEL_HI 1
`define CPMC_CR0_WSTOP 2
`define CPMC_CR0_SYSSEL 7
`define CPMC_CR0_DIV0 6
`define CPMC_CR1_HALT 0
`define CPMC_CR1_DIV_LO 6
`define CPMC_CR1_DIV_HI 7
`define CPMC_CR0_RESET 8'h48
`define CPMC_CR1_RESET 8'h20
`define CPMC_OSEL_PORT 2'h0
`define CPMC_OSEL_SUB 2'h1
`define CPMC_OSEL_DIV8 2'h2
`define CPMC_OSEL_DIV32 2'h3
`define CPMC_DIV1 2'h0
`define CPMC_DIV2 2'h1
`define CPMC_DIV4 2'h2
`define CPMC_DIV16 2'h3
`define CPMC_SUB_DIV 5'h1F
`endif

// ===== verilog/cpmc_divider.v
// Purpose: free-running prescaler giving one-cycle enable pulses
// Assumes: clk is the main clock, run gates all counting
// Notes: pulses land on the counter wrap so rate changes never shorten a period
`default_nettype none
module cpmc_divider
(
	input wire clk, // main clock
	input wire rstn, // async reset, active low
	input wire run, // count enable
	output wire [5:0] tick // tick[k] pulses every 2^k cycles (k>0)
);
	reg [4:0] cnt_reg;
	wire [4:0] cnt_next;

	assign cnt_next = cnt_reg + 5'h01;
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cnt_reg <= 5'h00;
		else if (run)
			cnt_reg <= cnt_next;
	end

	assign tick[0] = run;
	genvar k;
	generate
		for (k = 1; k < 6; k = k + 1)
		begin : gTick
			assign tick[k] = run & (cnt_reg[k-1:0] == {k{1'b1}});
		end
	endgenerate
endmodule
`default_nettype wire

// ===== verilog/cpmc_top.v
// Purpose: clock selection, base-clock division and stop/wait power modes
// Assumes: all inputs synchronous to clk; slow clocks are enable pulses
// Notes: register writes arrive already qualified by the protect bit
`default_nettype none
`include "cpmc_defs.vh"
// Functional notes
// - route div8, div32 or sub-clock to pin
// - select 00 port, 01 sub, 10 div8, 11 div32
// - wait with control byte 0 bit 2 set stops div8/div32 output
// - writing halt bit enters stop mode
// - stop halts base, peripheral, sub, converter clocks
// - external-clocked timers and serial keep working
// - reset or interrupt leaves stop mode
// - division bit0 set on fast-mode stop entry
// - stop in expansion: bus held, strobes high
// - stop single-chip: ports held, sub-clock pin high
// - wait stops base clock and watchdog
// - wait with control byte 0 bit 2 cuts peripheral clocks, not sub32
// - wait exits on reset or interrupt, same source
// - wait: bus held, strobes high in expansion, ports held
// - wait keeps sub output; div outputs per bit
// - reset gives main clock divided by 8
// - base divisors 2, 4, 8, 16 provided
// - div bit0 zero: field picks 1/2/4/16
module cpmc_top
(
	input wire clk, // main clock
	input wire rstn, // async reset, active low
	input wire ctrl0We, // write strobe for control byte 0
	input wire [7:0] ctrl0Wdata, // data for control byte 0
	input wire ctrl1We, // write strobe for control byte 1
	input wire [7:0] ctrl1Wdata, // data for control byte 1
	input wire waitExec, // pulse: wait instruction executed
	input wire wakeIrq, // pulse/level: enabled interrupt pending
	input wire singleChip, // 1 single-chip, 0 expansion/microprocessor
	input wire subTick, // one-cycle pulse per sub-clock period
	input wire extEventClk, // external clock for timers and serial units
	input wire [7:0] portIn, // general port value from core
	input wire [15:0] busIn, // address/data/chip-select value from core
	input wire [5:0] strobeIn, // read, write, hold ack, base, latch, upper-byte
	output reg [7:0] ctrl0Out, // control byte 0 readback
	output reg [7:0] ctrl1Out, // control byte 1 readback
	output reg stopMode, // stop mode active
	output reg waitMode, // wait mode active
	output wire wakeToIsr, // pulse: resume in service routine
	output wire baseClkEn, // cpu base clock enable
	output wire div8En, // peripheral div8 clock enable
	output wire div32En, // peripheral div32 clock enable
	output wire converterEn, // converter clock enable
	output wire subDirectEn, // sub-clock enable to core
	output wire subDiv32En, // sub-clock div32 enable
	output wire watchdogEn, // watchdog count enable
	output wire extPeriphEn, // external-clocked timer/serial enable
	output reg clkOutPin, // clock output pin level
	output wire clkOutOe, // clock output pin driven as clock
	output reg [7:0] portOut, // general port pins
	output reg [15:0] busOut, // bus and chip-select pins
	output reg [5:0] strobeOut // strobe pins
);
	localparam RUN = 3'b001;
	localparam STOP = 3'b010;
	localparam WAIT = 3'b100;

	reg [2:0] mode_reg;
	reg [2:0] mode_next;
	reg [4:0] subCnt_reg;
	reg [3:0] baseCnt_reg;
	reg [3:0] baseCnt_next;
	reg [3:0] divLimit_reg;
	reg periphCut_reg;
	reg div8Lvl_reg;
	reg div32Lvl_reg;
	reg subLvl_reg;
	wire [5:0] tick;
	wire running;
	wire stopping;
	wire [1:0] outSel;
	wire [3:0] divLimitSel;

	function [3:0] div_limit;
		input div0;
		input [1:0] sel;
		begin
			if (div0)
				div_limit = 4'h7;
			else
			begin
				case (sel)
					`CPMC_DIV1: div_limit = 4'h0;
					`CPMC_DIV2: div_limit = 4'h1;
					`CPMC_DIV4: div_limit = 4'h3;
					`CPMC_DIV16: div_limit = 4'hF;
					default: div_limit = 4'h7;
				endcase
			end
		end
	endfunction

	assign running = mode_reg[0];
	assign stopping = running & ctrl1We & ctrl1Wdata[`CPMC_CR1_HALT];

	// oscillators stop in stop mode only
	cpmc_divider uDiv
	(
		.clk(clk),
		.rstn(rstn),
		.run(~mode_reg[1]),
		.tick(tick)
	);

	always @*
	begin
		mode_next = mode_reg;
		case (mode_reg)
			RUN:
				if (stopping)
					mode_next = STOP;
				else if (waitExec)
					mode_next = WAIT;
			STOP:
				if (wakeIrq)
					mode_next = RUN;
			WAIT:
				if (wakeIrq)
					mode_next = RUN;
			default: mode_next = RUN;
		endcase
	end

	// wake input counts only enabled interrupts
	assign wakeToIsr = ~running & wakeIrq;

	// mode flags follow the state register edge for edge, so software status
	// and the gated clocks can never disagree about which mode is active
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stopMode <= 1'b0;
			waitMode <= 1'b0;
		end
		else
		begin
			stopMode <= (mode_next == STOP);
			waitMode <= (mode_next == WAIT);
		end
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode_reg <= RUN;
			ctrl0Out <= `CPMC_CR0_RESET;
			ctrl1Out <= `CPMC_CR1_RESET;
			periphCut_reg <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			if (running && ctrl0We)
				ctrl0Out <= ctrl0Wdata;
			if (stopping)
			begin
				ctrl1Out <= ctrl1Wdata;
				// fast modes force divide-by-8 on stop entry
				if (!ctrl0Out[`CPMC_CR0_SYSSEL])
					ctrl0Out[`CPMC_CR0_DIV0] <= 1'b1;
			end
			else if (running && ctrl1We)
				ctrl1Out <= ctrl1Wdata;
			if (mode_reg[1] && wakeIrq)
				ctrl1Out[`CPMC_CR1_HALT] <= 1'b0;
			// peripheral cut latched at wait entry
			if (running && waitExec && !stopping)
				periphCut_reg <= ctrl0Out[`CPMC_CR0_WSTOP];
			else if (running)
				periphCut_reg <= 1'b0;
		end
	end

	assign divLimitSel = div_limit(ctrl0Out[`CPMC_CR0_DIV0],
		{ctrl1Out[`CPMC_CR1_DIV_HI], ctrl1Out[`CPMC_CR1_DIV_LO]});

	always @*
	begin
		baseCnt_next = baseCnt_reg;
		if (running)
			baseCnt_next = (baseCnt_reg >= divLimit_reg) ? 4'h0 : baseCnt_reg + 4'h1;
	end

	// reset divisor 8; divisor kept across wait
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			baseCnt_reg <= 4'h0;
			divLimit_reg <= 4'h7;
		end
		else
		begin
			baseCnt_reg <= baseCnt_next;
			// new divisor only at the wrap
			if (running && baseCnt_reg >= divLimit_reg)
				divLimit_reg <= divLimitSel;
		end
	end

	// base enable at 1/2/4/8/16; gated off outside run
	assign baseClkEn = running & (baseCnt_reg >= divLimit_reg);
	assign watchdogEn = baseClkEn;

	// peripheral clocks cut in wait when latched
	assign div8En = tick[3] & ~(mode_reg[2] & periphCut_reg);
	assign div32En = tick[5] & ~(mode_reg[2] & periphCut_reg);
	assign converterEn = tick[0] & ~(mode_reg[2] & periphCut_reg);

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			subCnt_reg <= 5'h00;
		else if (subTick && !mode_reg[1])
			subCnt_reg <= subCnt_reg + 5'h01;
	end
	assign subDirectEn = subTick & ~mode_reg[1];
	assign subDiv32En = subDirectEn & (subCnt_reg == `CPMC_SUB_DIV);
	// external-clocked units keep counting in stop
	assign extPeriphEn = extEventClk;

	assign outSel = {ctrl0Out[`CPMC_CR0_OSEL_HI], ctrl0Out[`CPMC_CR0_OSEL_LO]};
	// pin carries a clock only in single-chip mode
	assign clkOutOe = singleChip & (outSel != `CPMC_OSEL_PORT);

	// square-wave levels toggle at half-period ticks, so they freeze when ticks stop
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div8Lvl_reg <= 1'b0;
			div32Lvl_reg <= 1'b0;
			subLvl_reg <= 1'b0;
		end
		else
		begin
			// frozen levels when wait cuts peripherals
			if (tick[2] && !(mode_reg[2] && periphCut_reg))
				div8Lvl_reg <= ~div8Lvl_reg;
			if (tick[4] && !(mode_reg[2] && periphCut_reg))
				div32Lvl_reg <= ~div32Lvl_reg;
			if (subDirectEn)
				subLvl_reg <= ~subLvl_reg;
		end
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			clkOutPin <= 1'b0;
		else
		begin
			case (outSel)
				// sub-clock selection drives high in stop
				`CPMC_OSEL_SUB: clkOutPin <= mode_reg[1] ? 1'b1 : subLvl_reg;
				`CPMC_OSEL_DIV8: clkOutPin <= div8Lvl_reg;
				`CPMC_OSEL_DIV32: clkOutPin <= div32Lvl_reg;
				default: clkOutPin <= 1'b0;
			endcase
		end
	end

	// pins follow the core while running; port and bus pins freeze otherwise
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			portOut <= 8'h00;
			busOut <= 16'h0000;
			strobeOut <= 6'h3F;
		end
		else if (running)
		begin
			portOut <= portIn;
			busOut <= busIn;
			strobeOut <= strobeIn;
		end
		// strobes high in stop and wait expansion modes
		else if (!singleChip)
			strobeOut <= 6'h3F;
	end
endmodule
`default_nettype wire

// ===== tb/cpmc_chk.sv
// Purpose: concurrent checks on the clock and power-mode controller ports
// Assumes: stop mode is seen through the halt bit of control byte 1
// Notes: spacing checks only bound the gap, so a late pulse passes
`default_nettype none
`include "cpmc_defs.vh"
module cpmc_chk
(
	input wire logic clk, // main clock
	input wire logic rstn, // async reset, active low
	input wire logic ctrl1We, // control byte 1 write
	input wire logic waitExec, // wait instruction
	input wire logic wakeIrq, // enabled interrupt
	input wire logic singleChip, // single-chip mode
	input wire logic extEventClk, // external clock in
	input wire logic [7:0] ctrl0Out, // control byte 0
	input wire logic [7:0] ctrl1Out, // control byte 1
	input wire logic wakeToIsr, // resume pulse
	input wire logic baseClkEn, // base clock
	input wire logic div8En, // div8 clock
	input wire logic div32En, // div32 clock
	input wire logic converterEn, // converter clock
	input wire logic subDirectEn, // sub-clock
	input wire logic subDiv32En, // sub-clock div32
	input wire logic watchdogEn, // watchdog clock
	input wire logic extPeriphEn, // external clock out
	input wire logic clkOutPin, // clock pin
	input wire logic clkOutOe, // clock pin enable
	input wire logic [7:0] portOut, // port pins
	input wire logic [15:0] busOut, // bus pins
	input wire logic [5:0] strobeOut // strobe pins
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
// second cycle of stop, when every pin has had its edge to freeze
sequence s_held(logic m);
	ctrl1Out[0] && $past(ctrl1Out[0]) && m;
endsequence
sequence s_wake;
	ctrl1Out[0] && wakeIrq;
endsequence
a_ext_clock_pass: assert property (extPeriphEn == extEventClk) else $error("ext clock not passed");
a_clock_output_pin_enable: assert property (clkOutOe == (singleChip && ctrl0Out[1:0] != `CPMC_OSEL_PORT))
	else $error("clock pin enable wrong");
a_stop_gates: assert property (ctrl1Out[0] |-> !(baseClkEn || div8En || div32En || converterEn
	|| subDirectEn || subDiv32En || watchdogEn)) else $error("clock runs in stop");
a_stop_div_set: assert property ($rose(ctrl1Out[0])
	|-> ctrl0Out[6] == ($past(ctrl0Out[7]) ? $past(ctrl0Out[6]) : 1'b1)) else $error("div bit not set");
a_wake_exit: assert property (s_wake |-> wakeToIsr ##1 !ctrl1Out[0]) else $error("no wake from stop");
a_bus_held: assert property (s_held(!singleChip) |-> strobeOut == 6'h3F && $stable(busOut))
	else $error("bus not held in stop");
a_pin_sub_high: assert property (s_held(singleChip && ctrl0Out[1:0] == `CPMC_OSEL_SUB)
	|-> clkOutPin && $stable(portOut)) else $error("pin not high in stop");
a_base_div8: assert property (baseClkEn && ctrl0Out[6] |=> !baseClkEn [*7])
	else $error("base period short");
a_wait_stop: assert property (waitExec && !ctrl1Out[0] && !ctrl1We && !wakeIrq
	|=> !baseClkEn && !watchdogEn && !(ctrl0Out[2] && (div8En || div32En || converterEn)))
	else $error("clock runs in wait");
endmodule
bind cpmc_top cpmc_chk cpmc_chk_inst (.*);
`default_nettype wire

// ===== tb/tb.sv
// Purpose: directed tests of the clock and power-mode controller
// Assumes: halt seen through control byte 1 bit 0, period sampled at negedge
// Notes: each period is measured twice, since a divisor change waits for a wrap
`default_nettype none
module tb;
timeunit 1ns;
timeprecision 1ps;
logic clk, rstn, ctrl0We, ctrl1We, waitExec, wakeIrq, singleChip, subTick, extEventClk;
logic [7:0] ctrl0Wdata, ctrl1Wdata, portIn, st;
logic [15:0] busIn, bSave;
logic [5:0] strobeIn;
wire [7:0] ctrl0Out, ctrl1Out, portOut;
wire [15:0] busOut;
wire [5:0] strobeOut;
wire stopMode, waitMode, wakeToIsr, baseClkEn, div8En, div32En, converterEn, subDirectEn;
wire subDiv32En, watchdogEn, extPeriphEn, clkOutPin, clkOutOe;
int mismatches, n_tests, cyc, p, a, b, c;
cpmc_top cpmc_top_inst (.*);
initial
begin
	clk = 0;
	forever #4 clk = ~clk;
end
// slow sources and changing core-side values so held pins are visible
always @(posedge clk)
begin
	st <= st + 8'h01;
	subTick <= (st[1:0] == 2'h0);
	extEventClk <= st[2];
	portIn <= st;
	busIn <= {st, ~st};
	strobeIn <= st[5:0];
	cyc++;
	if (cyc == 20000)
	begin
		mismatches++;
		print_verdict;
	end
end
task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	n_tests++;
	if (g !== e)
	begin
		mismatches++;
		$display("wrong value %s expected %h seen %h", nm, e, g);
	end
endtask
// each write stands for an access already allowed by the protect bit
task wr(input logic w1, input logic [7:0] d);
	@(posedge clk);
	ctrl0We <= !w1;
	ctrl1We <= w1;
	ctrl0Wdata <= d;
	ctrl1Wdata <= d;
	@(posedge clk);
	ctrl0We <= 0;
	ctrl1We <= 0;
endtask
task per1;
	int k;
	k = 0;
	p = 0;
	@(negedge clk);
	while (baseClkEn !== 1 && k < 80)
	begin
		@(negedge clk);
		k++;
	end
	do
	begin
		@(negedge clk);
		p++;
	end while (baseClkEn !== 1 && p < 80);
endtask
task per(input int e);
	per1;
	per1;
	chk("base period", e, p);
endtask
task cnt(input int n);
	a = 0;
	b = 0;
	c = 0;
	repeat (n)
	begin
		@(negedge clk);
		a += (baseClkEn === 1);
		b += (div8En === 1);
		c += (subDiv32En === 1);
	end
endtask
task wake;
	// only an interrupt that software enabled is ever raised
	@(posedge clk);
	wakeIrq <= 1;
	@(negedge clk);
	chk("wakeToIsr", 1, wakeToIsr);
	@(posedge clk);
	wakeIrq <= 0;
	@(negedge clk);
	chk("halt bit", 0, ctrl1Out[0]);
endtask
task halt(input logic w);
	if (w)
	begin
		@(posedge clk);
		waitExec <= 1;
		@(posedge clk);
		waitExec <= 0;
	end
	else
		wr(1, 8'h01);
	// the pin register lags the level flops by one edge, so let it settle
	@(negedge clk);
	@(negedge clk);
	bSave = {busOut[15:8], clkOutPin, portOut[6:0]};
endtask
task t_div;
	int e[4] = '{1, 2, 4, 16};
	// main oscillator taken as stable before leaving divide-by-8
	wr(0, 8'h08);
	for (int i = 0; i < 4; i++)
	begin
		wr(1, {i[1:0], 6'h20});
		per(e[i]);
	end
	$display("t_div done");
endtask
task t_stop;
	halt(0);
	@(negedge clk);
	bSave = busOut;
	cnt(40);
	chk("stop base pulses", 0, a);
	chk("stop div8 pulses", 0, b);
	chk("held bus", bSave, busOut);
	chk("stop strobes", 16'h3F, strobeOut);
	chk("div bit0", 1, ctrl0Out[6]);
	chk("stop flag", 1, stopMode);
	wake;
	chk("stop flag clear", 0, stopMode);
	per(8);
	$display("t_stop done");
endtask
task t_wait;
	singleChip <= 1;
	wr(0, 8'h4E);
	halt(1);
	chk("wait flag", 1, waitMode);
	cnt(130);
	chk("wait base pulses", 0, a);
	chk("wait div8 pulses", 0, b);
	chk("wait sub32 runs", 1, c > 0);
	chk("frozen pin", bSave[7], clkOutPin);
	wake;
	chk("wait flag clear", 0, waitMode);
	per(8);
	wr(0, 8'h49);
	halt(1);
	cnt(64);
	chk("wait div8 runs", 1, b > 0);
	wake;
	$display("t_wait done");
endtask
task t_clock_output_pin;
	for (int i = 0; i < 4; i++)
	begin
		wr(0, 8'h48 | i[7:0]);
		@(negedge clk);
		chk("clock pin enable", i != 0, clkOutOe);
	end
	wr(0, 8'h49);
	halt(0);
	cnt(20);
	chk("stop sub pin", 1, clkOutPin);
	chk("held port", bSave[6:0], portOut[6:0]);
	wake;
	$display("t_clock_output_pin done");
endtask
task print_verdict;
	$display("tests %0d mismatches %0d", n_tests, mismatches);
	if (mismatches == 0 && n_tests > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
initial
begin
	{rstn, ctrl0We, ctrl1We, waitExec, wakeIrq, singleChip, subTick, extEventClk} = 0;
	{ctrl0Wdata, ctrl1Wdata, portIn, busIn, strobeIn, st} = 0;
	repeat (6) @(posedge clk);
	chk("reset strobes", 16'h3F, strobeOut);
	rstn <= 1;
	@(negedge clk);
	chk("ctrl0 reset", 16'h48, ctrl0Out);
	chk("ctrl1 reset", 16'h20, ctrl1Out);
	per(8);
	t_div;
	t_stop;
	t_wait;
	t_clock_output_pin;
	print_verdict;
end
endmodule
`default_nettype wire
